// >>> hw/fwel_pkg.sv
package fwel_pkg;
  // command opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
  localparam logic [7:0] CONTINUOUS_PROGRAM_CMD = 8'hAD;
  localparam logic [7:0] SECTOR_WIPE_CMD = 8'h20;
  localparam logic [7:0] BLOCK_ERASE_64K_CMD = 8'hD8;
  localparam logic [7:0] BLOCK_ERASE_32K_CMD = 8'h52;
  localparam logic [7:0] CHIP_ERASE_CMD = 8'h60;
  localparam logic [7:0] CHIP_ERASE_ALT_CMD = 8'hC7;
  localparam logic [7:0] SINGLE_LOCK_CMD = 8'h36;
  localparam logic [7:0] SINGLE_UNLOCK_CMD = 8'h39;
  localparam logic [7:0] GANG_LOCK_CMD = 8'h7E;
  localparam logic [7:0] GANG_UNLOCK_CMD = 8'h98;
  localparam logic [7:0] LOCK_STATE_QUERY_CMD = 8'h3C;
  localparam logic [7:0] PROTECT_SCHEME_SELECT_CMD = 8'h68;

  // protection granularity: one lock bit per 64 KB block
  localparam int BLOCK_COUNT = 128;
  localparam int BLOCK_ADDR_LSB = 16;
  localparam int BLOCK_ADDR_MSB = 22;

  // frame lengths in serial clock edges
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [CNT_W-1:0] OPCODE_BITS = 12'h008;
  localparam logic [CNT_W-1:0] STATUS_WRITE_BITS = 12'h010;
  localparam logic [CNT_W-1:0] ADDR_FRAME_BITS = 12'h020;
  localparam logic [CNT_W-1:0] PROGRAM_MIN_BITS = 12'h028;
  localparam logic [CNT_W-1:0] CONT_MIN_BITS = 12'h030;

  // status byte layout
  localparam int WIP_BIT = 0;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int STATUS_HIGH_LSB = 2;
  localparam int BP_LSB = 0;
  localparam int BP_MSB = 3;
  localparam logic [7:0] LOCK_REPLY_SET = 8'hFF;
  localparam logic [7:0] LOCK_REPLY_CLEAR = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE, OP_PROGRAM, OP_QUAD_PROGRAM, OP_CONT_PROGRAM, OP_SECTOR_WIPE,
    OP_ERASE_64K, OP_ERASE_32K, OP_CHIP_ERASE, OP_STATUS_WRITE
  } fwelOp_t;

  typedef struct packed {
    fwelOp_t kind;
    logic [23:0] addr;
  } fwelOpReq_t;

  typedef struct packed {
    logic tag;
    logic [CNT_W-1:0] bits;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
  } fwelHold_t;

  typedef struct packed {
    logic [CNT_W-1:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic outEnN;
    logic [7:0] statusSync1;
    logic [7:0] statusSync2;
    logic [7:0] statusSync3;
    logic [7:0] statusStable;
    logic [BLOCK_COUNT-1:0] lockSync1;
    logic [BLOCK_COUNT-1:0] lockSync2;
  } fwelLink_t;

  typedef struct packed {
    logic holdRun;
    logic csSync1;
    logic csSync2;
    logic csPrev;
    logic lastTag;
    logic writeLatchFlag;
    logic busy;
    logic indivMode;
    logic [BLOCK_COUNT-1:0] locks;
    logic [5:0] statusHigh;
    logic [5:0] pending;
    logic opStart;
    fwelOpReq_t req;
    logic [7:0] statusByte;
  } fwelCore_t;
endpackage

// >>> hw/fwel_latch.sv
`timescale 1ns/100ps
// Notes on behaviour
// - a complete write-enable frame sets the write latch flag
// - a complete write-disable frame clears the write latch flag
// - flag is clear after power-up until write-enable sets it
// - flag clears when a status write completes
// - flag clears when single or quad page program completes
// - flag clears when continuous program completes
// - flag clears when sector, 64K, 32K block or chip erase completes
// - flag clears when single-block lock or unlock completes
// - flag clears when gang lock or gang unlock completes
// - entering individual protection mode locks every block
// - opcode 3C plus 24-bit address returns the block lock state
// - opcode 68 without address selects individual block protection
// - flag sits at status bit 1; status write data does not set it
// - with flag clear, program, erase and status write are refused
// - program or erase to a protected area is ignored, clears flag
module fwel_latch
  import fwel_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEnN,
  input wire logic opDone,
  output logic opStart,
  output fwelOpReq_t opReq,
  output logic writeLatchFlag,
  output logic busy,
  output logic indivMode,
  output logic [7:0] statusByte
);

  localparam fwelLink_t LINK_IDLE = '{outEnN: 1'b1, default: '0};
  // select synchronisers start at the idle level: no false edge after reset
  localparam fwelCore_t CORE_IDLE = '{csSync1: 1'b1, csSync2: 1'b1,
    csPrev: 1'b1, req: '{kind: OP_NONE, addr: 24'h000000}, default: '0};

  fwelLink_t link;
  fwelLink_t next_link;
  fwelHold_t hold;
  fwelHold_t next_hold;
  fwelCore_t core;
  fwelCore_t next_core;
  logic holdClr;
  logic [23:0] fullAddr;
  logic frameEnd;
  fwelOp_t reqKind;
  logic protHit;
  logic exact8;
  logic exact32;
  logic byteAligned;
  logic [BLOCK_ADDR_MSB-BLOCK_ADDR_LSB:0] blockIdx;

  //////////////////////////////////////////////////////////////////////////
  // link side: serial clock, counting state cleared while select is high

  assign holdClr = ~core.holdRun;
  assign fullAddr = {hold.addr[22:0], serialIn};

  always_comb begin
    next_link = link;
    next_hold = hold;
    next_link.statusSync1 = core.statusByte;
    next_link.statusSync2 = link.statusSync1;
    next_link.statusSync3 = link.statusSync2;
    // two equal samples in a row: a word caught mid-change is never used
    if (link.statusSync3 == link.statusSync2) begin
      next_link.statusStable = link.statusSync2;
    end
    next_link.lockSync1 = core.locks;
    next_link.lockSync2 = link.lockSync1;
    next_link.shiftIn = {link.shiftIn[6:0], serialIn};
    next_link.shiftOut = {link.shiftOut[6:0], 1'b0};
    if (link.bitCnt != CNT_MAX) begin
      next_link.bitCnt = link.bitCnt + 12'h001;
    end
    // tag flips once per frame so an empty frame is never replayed
    if (link.bitCnt == '0) begin
      next_hold.tag = ~hold.tag;
    end
    next_hold.bits = next_link.bitCnt;
    if (link.bitCnt == OPCODE_BITS - 12'h001) begin
      next_hold.opcode = next_link.shiftIn;
    end
    if (link.bitCnt >= OPCODE_BITS && link.bitCnt < ADDR_FRAME_BITS) begin
      next_hold.addr = fullAddr;
    end
    if (link.bitCnt == STATUS_WRITE_BITS - 12'h001) begin
      next_hold.data = next_link.shiftIn;
    end
    // status read streams the byte again after every eighth edge
    if (link.bitCnt == OPCODE_BITS - 12'h001 &&
        next_link.shiftIn == STATUS_READ_CMD) begin
      next_link.shiftOut = link.statusStable;
      next_link.outEnN = 1'b0;
    end else if (!link.outEnN && hold.opcode == STATUS_READ_CMD &&
                 link.bitCnt[2:0] == 3'h7) begin
      next_link.shiftOut = link.statusStable;
    end
    if (link.bitCnt == ADDR_FRAME_BITS - 12'h001 &&
        hold.opcode == LOCK_STATE_QUERY_CMD) begin
      next_link.outEnN = 1'b0;
      next_link.shiftOut =
        link.lockSync2[fullAddr[BLOCK_ADDR_MSB:BLOCK_ADDR_LSB]] ?
        LOCK_REPLY_SET : LOCK_REPLY_CLEAR;
    end
  end

  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      link <= LINK_IDLE;
    end else begin
      link <= next_link;
    end
  end

  // held words survive select going high; the core reads them quiescent
  always_ff @(posedge linkClk or posedge holdClr) begin
    if (holdClr) begin
      hold <= '0;
    end else begin
      hold <= next_hold;
    end
  end

  assign serialOut = link.shiftOut[7];
  assign serialOutEnN = link.outEnN;

  //////////////////////////////////////////////////////////////////////////
  // core side: decode at frame end, latch flag and protection state

  assign exact8 = hold.bits == OPCODE_BITS;
  assign exact32 = hold.bits == ADDR_FRAME_BITS;
  assign byteAligned = hold.bits[2:0] == 3'h0;
  assign blockIdx = hold.addr[BLOCK_ADDR_MSB:BLOCK_ADDR_LSB];
  assign frameEnd = core.csSync2 && !core.csPrev &&
                    (hold.tag != core.lastTag);

  always_comb begin
    reqKind = OP_NONE;
    case (hold.opcode)
      PAGE_PROGRAM_CMD: begin
        if (byteAligned && hold.bits >= PROGRAM_MIN_BITS) begin
          reqKind = OP_PROGRAM;
        end
      end
      QUAD_PAGE_PROGRAM_CMD: begin
        if (byteAligned && hold.bits >= PROGRAM_MIN_BITS) begin
          reqKind = OP_QUAD_PROGRAM;
        end
      end
      CONTINUOUS_PROGRAM_CMD: begin
        if (byteAligned && hold.bits >= CONT_MIN_BITS) begin
          reqKind = OP_CONT_PROGRAM;
        end
      end
      SECTOR_WIPE_CMD: begin
        if (exact32) begin
          reqKind = OP_SECTOR_WIPE;
        end
      end
      BLOCK_ERASE_64K_CMD: begin
        if (exact32) begin
          reqKind = OP_ERASE_64K;
        end
      end
      BLOCK_ERASE_32K_CMD: begin
        if (exact32) begin
          reqKind = OP_ERASE_32K;
        end
      end
      CHIP_ERASE_CMD, CHIP_ERASE_ALT_CMD: begin
        if (exact8) begin
          reqKind = OP_CHIP_ERASE;
        end
      end
      STATUS_WRITE_CMD: begin
        if (hold.bits == STATUS_WRITE_BITS) begin
          reqKind = OP_STATUS_WRITE;
        end
      end
      default: begin
        reqKind = OP_NONE;
      end
    endcase
  end

  // block-protect levels guard the whole array; no partial map kept here
  always_comb begin
    if (reqKind == OP_CHIP_ERASE) begin
      protHit = core.indivMode ? |core.locks :
                core.statusHigh[BP_MSB:BP_LSB] != 4'h0;
    end else begin
      protHit = core.indivMode ? core.locks[blockIdx] :
                core.statusHigh[BP_MSB:BP_LSB] != 4'h0;
    end
  end

  always_comb begin
    next_core = core;
    next_core.holdRun = 1'b1;
    next_core.csSync1 = csN;
    next_core.csSync2 = core.csSync1;
    next_core.csPrev = core.csSync2;
    next_core.opStart = 1'b0;
    if (core.busy && opDone) begin
      next_core.busy = 1'b0;
      next_core.writeLatchFlag = 1'b0;
      if (core.req.kind == OP_STATUS_WRITE) begin
        next_core.statusHigh = core.pending;
      end
    end
    if (frameEnd) begin
      next_core.lastTag = hold.tag;
    end
    // undefined opcodes fall through every branch and change nothing
    if (frameEnd && !core.busy) begin
      if (reqKind != OP_NONE && core.writeLatchFlag) begin
        if (protHit && reqKind != OP_STATUS_WRITE) begin
          next_core.writeLatchFlag = 1'b0;
        end else begin
          next_core.opStart = 1'b1;
          next_core.busy = 1'b1;
          next_core.req.kind = reqKind;
          next_core.req.addr = hold.addr;
          next_core.pending = hold.data[7:STATUS_HIGH_LSB];
        end
      end
      if (exact8) begin
        case (hold.opcode)
          WRITE_ENABLE_CMD: begin
            next_core.writeLatchFlag = 1'b1;
          end
          WRITE_DISABLE_CMD: begin
            next_core.writeLatchFlag = 1'b0;
          end
          GANG_LOCK_CMD, GANG_UNLOCK_CMD: begin
            if (core.writeLatchFlag) begin
              next_core.writeLatchFlag = 1'b0;
              if (core.indivMode) begin
                next_core.locks = {BLOCK_COUNT{hold.opcode == GANG_LOCK_CMD}};
              end
            end
          end
          PROTECT_SCHEME_SELECT_CMD: begin
            next_core.indivMode = 1'b1;
            if (!core.indivMode) begin
              next_core.locks = {BLOCK_COUNT{1'b1}};
            end
          end
          default: begin
            next_core.indivMode = core.indivMode;
          end
        endcase
      end
      if (exact32 && core.writeLatchFlag &&
          (hold.opcode == SINGLE_LOCK_CMD ||
           hold.opcode == SINGLE_UNLOCK_CMD)) begin
        next_core.writeLatchFlag = 1'b0;
        if (core.indivMode) begin
          next_core.locks[blockIdx] = hold.opcode == SINGLE_LOCK_CMD;
        end
      end
    end
    next_core.statusByte = {next_core.statusHigh, next_core.writeLatchFlag,
                            next_core.busy};
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core <= CORE_IDLE;
    end else begin
      core <= next_core;
    end
  end

  assign opStart = core.opStart;
  assign opReq = core.req;
  assign writeLatchFlag = core.writeLatchFlag;
  assign busy = core.busy;
  assign indivMode = core.indivMode;
  assign statusByte = core.statusByte;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence enableFrame;
    frameEnd && !busy && exact8 && hold.opcode == WRITE_ENABLE_CMD;
  endsequence

  sequence disableFrame;
    frameEnd && !busy && exact8 && hold.opcode == WRITE_DISABLE_CMD;
  endsequence

  sequence modifyFrame;
    frameEnd && !busy && reqKind != OP_NONE;
  endsequence

  latch_set_a: assert property (enableFrame |=> writeLatchFlag
      && statusByte[WRITE_LATCH_BIT])
    else $error("write enable did not set the latch");

  latch_clear_a: assert property (disableFrame |=> !writeLatchFlag)
    else $error("write disable did not clear the latch");

  reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      sys_rst |=> !writeLatchFlag && !busy)
    else $error("latch not clear after reset");

  done_clear_a: assert property (busy && opDone |=> !writeLatchFlag
      && !busy && !opStart)
    else $error("completion did not clear latch and busy");

  refuse_op_a: assert property (modifyFrame and ##0 !writeLatchFlag
      |=> !opStart && !busy && !writeLatchFlag)
    else $error("command accepted with latch clear");

  protect_ignore_a: assert property (modifyFrame and ##0 (writeLatchFlag
      && protHit && reqKind != OP_STATUS_WRITE) |=> !opStart && !busy
      && !writeLatchFlag)
    else $error("protected area not refused");

  scheme_lock_a: assert property (frameEnd && !busy && exact8
      && !indivMode && hold.opcode == PROTECT_SCHEME_SELECT_CMD
      |=> indivMode && (&core.locks))
    else $error("scheme select did not lock all blocks");

  status_keep_a: assert property (busy && opDone
      && core.req.kind == OP_STATUS_WRITE |=> statusByte[7:2] ==
      $past(core.pending) && !statusByte[WRITE_LATCH_BIT])
    else $error("status write result wrong");

  gang_clear_a: assert property (frameEnd && !busy && exact8
      && writeLatchFlag && hold.opcode == GANG_LOCK_CMD |=> !writeLatchFlag)
    else $error("gang lock did not clear latch");

  query_reply_a: assert property (@(posedge linkClk) disable iff (csN)
      link.bitCnt == ADDR_FRAME_BITS - 12'h001
      && hold.opcode == LOCK_STATE_QUERY_CMD |=> !serialOutEnN)
    else $error("lock query gave no reply");

endmodule // fwel_latch

// >>> sim/fwel_host_model.sv
`timescale 1ns/100ps
module fwel_host_model (
  output logic linkClk,
  output logic csN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  logic [63:0] rx;

  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    serialIn = 1'b0;
    rx = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one whole frame, msb first, only defined opcodes are sent
  // select low, n bits, select high; clock parked low outside
  // address and dummy bits follow the opcode as framed
  task automatic frame(input logic [63:0] bits, input int n);
    csN = 1'b0;
    #4;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #3;
      // taken just before the rise, where the reply bit has stood a cycle
      // undriven output captured as unknown so it never passes as data
      rx = {rx[62:0], serialOutEnN ? 1'bx : serialOut};
      linkClk = 1'b1;
      #3 linkClk = 1'b0;
    end
    #4;
    csN = 1'b1;
    // released line: last value inverted, not left looking valid
    serialIn = ~serialIn;
    #30;
  endtask
endmodule // fwel_host_model

// >>> sim/tb_flash_write_enable_latch.sv
`timescale 1ns/100ps
module tb_flash_write_enable_latch;
  import fwel_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic opDone = 1'b0;
  logic linkClk;
  logic csN;
  logic serialIn;
  logic serialOut;
  logic serialOutEnN;
  logic opStart;
  fwelOpReq_t opReq;
  logic writeLatchFlag;
  logic busy;
  logic indivMode;
  logic [7:0] statusByte;
  int n_mismatch = 0;
  int cmp_count = 0;
  int starts = 0;
  int k;
  fwelOp_t lastKind = OP_NONE;
  logic [63:0] opFrame [9] = '{64'h02_010000_A5, 64'h38_010000_A5,
    64'hAD_010000_A5A5, 64'h20_010000, 64'hD8_010000, 64'h52_010000,
    64'h60, 64'hC7, 64'h0103};
  int opBits [9] = '{40, 40, 48, 32, 32, 32, 8, 8, 16};
  fwelOp_t opKind [9] = '{OP_PROGRAM, OP_QUAD_PROGRAM, OP_CONT_PROGRAM,
    OP_SECTOR_WIPE, OP_ERASE_64K, OP_ERASE_32K, OP_CHIP_ERASE,
    OP_CHIP_ERASE, OP_STATUS_WRITE};

  always #2.5 ref_clk = ~ref_clk;

  fwel_latch uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .linkClk(linkClk), .csN(csN),
    .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .opDone(opDone), .opStart(opStart),
    .opReq(opReq), .writeLatchFlag(writeLatchFlag), .busy(busy),
    .indivMode(indivMode), .statusByte(statusByte)
  );

  fwel_host_model host (
    .linkClk(linkClk), .csN(csN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN)
  );

  always @(negedge ref_clk) begin
    if (opStart === 1'b1) begin
      starts++;
      lastKind = opReq.kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // frame end reaches the core outputs within 3 cycles; 8 leaves margin
  task automatic cmd(input logic [63:0] bits, input int n);
    host.frame(bits, n);
    wt(8);
  endtask

  task automatic finish_op();
    opDone = 1'b1;
    wt(1);
    opDone = 1'b0;
    wt(2);
  endtask

  task automatic query(input logic [23:0] a, input logic [7:0] exp);
    cmd({24'h000000, 8'h3C, a, 8'h00}, 40);
    check(host.rx[7:0], exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(4);
    sys_rst = 1'b0;
    wt(4);
    check(writeLatchFlag, 1'b0);
    check(statusByte, 8'h00);
    cmd(64'h01FC, 16);
    cmd(64'h02_010000_A5, 40);
    check(starts, 0);
    check(writeLatchFlag, 1'b0);
    // one clock too many: the frame is not a write-enable
    cmd(64'h0D, 9);
    check(writeLatchFlag, 1'b0);
    cmd(64'h06, 8);
    check(writeLatchFlag, 1'b1);
    cmd(64'h0500, 16);
    check(host.rx[7:0], 8'h02);
    cmd(64'h04, 8);
    check(writeLatchFlag, 1'b0);
    for (int i = 0; i < 9; i++) begin
      cmd(64'h06, 8);
      k = starts;
      cmd(opFrame[i], opBits[i]);
      check(starts - k, 1);
      check(lastKind, opKind[i]);
      check(busy, 1'b1);
      if (i < 6) begin
        check(opReq.addr, 24'h01_0000);
      end
      finish_op();
      check(writeLatchFlag, 1'b0);
      check(statusByte, 8'h00);
    end
    // nonzero protect level guards the whole array in the default scheme
    cmd(64'h06, 8);
    cmd(64'h013C, 16);
    check(busy, 1'b1);
    finish_op();
    check(statusByte, 8'h3C);
    cmd(64'h06, 8);
    k = starts;
    cmd(64'h20_010000, 32);
    check(starts - k, 0);
    check(writeLatchFlag, 1'b0);
    cmd(64'h06, 8);
    cmd(64'h0100, 16);
    finish_op();
    check(statusByte, 8'h00);
    cmd(64'h68, 8);
    check(indivMode, 1'b1);
    query(24'h05_0000, 8'hFF);
    cmd(64'h06, 8);
    cmd(64'h39_050000, 32);
    check(writeLatchFlag, 1'b0);
    query(24'h05_0000, 8'h00);
    cmd(64'h06, 8);
    cmd(64'h36_050000, 32);
    check(writeLatchFlag, 1'b0);
    query(24'h05_0000, 8'hFF);
    cmd(64'h06, 8);
    cmd(64'h98, 8);
    check(writeLatchFlag, 1'b0);
    query(24'h7F_0000, 8'h00);
    cmd(64'h06, 8);
    cmd(64'h7E, 8);
    check(writeLatchFlag, 1'b0);
    query(24'h00_0000, 8'hFF);
    // locked target: nothing starts, latch still drops
    cmd(64'h06, 8);
    k = starts;
    cmd(64'h02_000000_5A, 40);
    check(starts - k, 0);
    check(writeLatchFlag, 1'b0);
    // reset in mid-run drops the latch and the scheme choice
    cmd(64'h06, 8);
    check(writeLatchFlag, 1'b1);
    sys_rst = 1'b1;
    wt(4);
    sys_rst = 1'b0;
    wt(4);
    check(writeLatchFlag, 1'b0);
    check(indivMode, 1'b0);
    cmd(64'h06, 8);
    check(writeLatchFlag, 1'b1);
    end_of_test();
  end
endmodule // tb_flash_write_enable_latch
